// file: rtl/status_flag_pkg.sv
// status_flag_pkg: offsets, field positions, reset values and bus types
// for the processor status register block and its axi4-lite slave.
package status_flag_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] STATUS_OFFSET = 4'h0;  // processor_status_flags
  localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h4;  // sticky events, read only
  localparam logic [3:0] IRQ_ENABLE_OFFSET = 4'h8;  // event enables
  localparam logic [3:0] IRQ_CLEAR_OFFSET = 4'hc;  // write 1 to clear

  // ------------------------------------------------------------
  // status bit positions, bit 0 up to bit 7
  // ------------------------------------------------------------
  localparam int CARRY_BIT = 0;
  localparam int NIBBLE_BIT = 1;
  localparam int NULL_BIT = 2;
  localparam int SLEEP_BIT = 3;
  localparam int EXPIRED_BIT = 4;
  localparam int BANK_BIT = 5;
  localparam int SPARE_BIT = 6;
  localparam int SUPPLY_BIT = 7;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  // bits that software may write directly
  localparam logic [7:0] SW_WRITE_MASK = 8'h67;

  // ------------------------------------------------------------
  // event bit positions in the interrupt registers
  // ------------------------------------------------------------
  localparam int EV_EXPIRED = 0;
  localparam int EV_SUPPLY_LOW = 1;
  localparam int EV_SLEEP = 2;
  localparam int EV_COUNT = 3;
  localparam logic [EV_COUNT-1:0] EV_RESET = 3'h0;

  // ------------------------------------------------------------
  // bus response codes
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // alu result report from the core, valid for one cycle
  typedef struct packed {
    logic valid;        // one-cycle pulse
    logic is_logic;     // logic op: only result-null updates
    logic is_sub;       // subtract: carry and nibble mean no-borrow
    logic nibble_out;   // carry out of bit 3 (add) or not-borrow (sub)
    logic carry_out;    // carry out of bit 7 (add) or not-borrow (sub)
    logic [7:0] result; // result byte
  } alu_report_t;

  // instruction and event strobes, each a one-cycle pulse
  typedef struct packed {
    logic wdt_clear;    // watchdog_clear_instr executed
    logic sleep;        // sleep instruction executed
    logic wdt_timeout;  // watchdog expired
    logic brownout;     // brownout_reset occurred
  } core_events_t;

  // direct core access: write full byte, set or clear one bit
  typedef struct packed {
    logic write;        // write byte under software mask
    logic bit_set;      // set bit at bit_sel
    logic bit_clear;    // clear bit at bit_sel
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } core_write_t;

endpackage

// file: rtl/status_flag_register.sv
// status_flag_register: eight-bit processor status register with
// core-side update ports and an axi4-lite register slave.
// assumes alu, watchdog and reset strobes are synchronous to I_CORE_CLK;
// the supply comparator and brown-out enable come from pins.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module status_flag_register (
  input wire logic I_CORE_CLK,                      // core clock, 125 mhz
  input wire logic I_RESETN,                        // synchronous reset, active low
  input wire status_flag_pkg::alu_report_t I_ALU,   // alu result report
  input wire status_flag_pkg::core_events_t I_EVT,  // instruction and event strobes
  input wire status_flag_pkg::core_write_t I_CORE_WR, // core direct write
  input wire logic I_SUPPLY_BELOW,                  // comparator pin, async
  input wire logic I_BROWNOUT_EN,                   // brown-out enable pin, async
  input wire logic I_BROWNOUT_HIGH,                 // level select pin, async
  output logic [7:0] O_STATUS,                      // register value to core
  output logic O_BANK_SELECT,                       // data memory bank
  output logic O_THRESHOLD_HIGH,                    // 1: 3.1v detect, 0: 2.2v
  output logic O_IRQ,                               // level interrupt
  input wire logic [3:0] S_AXI_AWADDR,              // write address
  input wire logic S_AXI_AWVALID,                   // write address valid
  output logic S_AXI_AWREADY,                       // write address ready
  input wire logic [31:0] S_AXI_WDATA,              // write data
  input wire logic [3:0] S_AXI_WSTRB,               // write strobes
  input wire logic S_AXI_WVALID,                    // write data valid
  output logic S_AXI_WREADY,                        // write data ready
  output logic [1:0] S_AXI_BRESP,                   // write response
  output logic S_AXI_BVALID,                        // write response valid
  input wire logic S_AXI_BREADY,                    // write response ready
  input wire logic [3:0] S_AXI_ARADDR,              // read address
  input wire logic S_AXI_ARVALID,                   // read address valid
  output logic S_AXI_ARREADY,                       // read address ready
  output logic [31:0] S_AXI_RDATA,                  // read data
  output logic [1:0] S_AXI_RRESP,                   // read response
  output logic S_AXI_RVALID,                        // read data valid
  input wire logic S_AXI_RREADY                     // read data ready
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  // two stages; only the second stage feeds logic
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {I_BROWNOUT_HIGH, I_BROWNOUT_EN, I_SUPPLY_BELOW};
      pin_sync <= pin_meta;
    end
  end

  wire supply_below = pin_sync[0];
  wire brownout_en = pin_sync[1];
  wire level_high = pin_sync[2];

  // ------------------------------------------------------------
  // status register update
  // ------------------------------------------------------------
  logic [6:0] flags;        // bits 6..0; bit 7 is the supply_low flop fed by the synchronised comparator, gated by brown-out enable
  logic [6:0] next_flags;
  logic supply_low;

  // supply-low follows the comparator, forced low without brown-out
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      supply_low <= 1'b0;
    end else begin
      supply_low <= supply_below & brownout_en;
    end
  end

  // bus write to the status offset acts like a core byte write
  logic bus_status_wr;
  logic [7:0] bus_wbyte;

  wire core_byte_wr = I_CORE_WR.write | bus_status_wr;
  wire [7:0] byte_src = I_CORE_WR.write ? I_CORE_WR.wdata : bus_wbyte;
  wire [7:0] bit_onehot = 8'h01 << I_CORE_WR.bit_sel;
  wire [7:0] sw_mask = status_flag_pkg::SW_WRITE_MASK;
  wire result_zero = (I_ALU.result == 8'h00);

  // order: software writes, then alu, then hardware-owned event flags;
  // later sources win so a same-cycle hardware event is never lost
  always_comb begin
    logic [7:0] v;
    v = {1'b0, flags};
    if (core_byte_wr) begin
      v = (v & ~sw_mask) | (byte_src & sw_mask);
    end
    if (I_CORE_WR.bit_set) begin
      v = v | (bit_onehot & sw_mask);
    end
    if (I_CORE_WR.bit_clear) begin
      v = v & ~(bit_onehot & sw_mask);
    end
    if (I_ALU.valid) begin
      v[status_flag_pkg::NULL_BIT] = result_zero;
      if (!I_ALU.is_logic) begin
        v[status_flag_pkg::NIBBLE_BIT] = I_ALU.nibble_out;
        v[status_flag_pkg::CARRY_BIT] = I_ALU.carry_out;
      end
    end
    if (I_EVT.brownout || I_EVT.wdt_clear || I_EVT.sleep) begin
      v[status_flag_pkg::EXPIRED_BIT] = 1'b0;
    end
    if (I_EVT.wdt_timeout) begin
      v[status_flag_pkg::EXPIRED_BIT] = 1'b1;
    end
    if (I_EVT.brownout || I_EVT.wdt_clear) begin
      v[status_flag_pkg::SLEEP_BIT] = 1'b0;
    end
    if (I_EVT.sleep) begin
      v[status_flag_pkg::SLEEP_BIT] = 1'b1;
    end
    next_flags = v[6:0];
  end

  // spare bit needs no logic beyond storage under the write mask
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      flags <= status_flag_pkg::STATUS_RESET[6:0];
    end else begin
      flags <= next_flags;
    end
  end

  assign O_STATUS = {supply_low, flags};
  assign O_BANK_SELECT = flags[status_flag_pkg::BANK_BIT];
  assign O_THRESHOLD_HIGH = level_high;

  // ------------------------------------------------------------
  // interrupt events
  // ------------------------------------------------------------
  logic [status_flag_pkg::EV_COUNT-1:0] irq_status;
  logic [status_flag_pkg::EV_COUNT-1:0] irq_enable;
  logic [status_flag_pkg::EV_COUNT-1:0] irq_clear;
  logic supply_low_d;

  wire [status_flag_pkg::EV_COUNT-1:0] ev_pulse = {
    I_EVT.sleep, supply_low & ~supply_low_d, I_EVT.wdt_timeout};

  // set wins over a clear in the same cycle
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      irq_status <= status_flag_pkg::EV_RESET;
      supply_low_d <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | ev_pulse;
      supply_low_d <= supply_low;
    end
  end

  assign O_IRQ = |(irq_status & irq_enable);

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;

  // each channel is taken on its own; the write acts once both are held
  // and no response is pending, keeping one write in flight
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  wire write_go = aw_held && w_held;
  wire wr_mapped = (aw_addr == status_flag_pkg::STATUS_OFFSET) ||
                   (aw_addr == status_flag_pkg::IRQ_ENABLE_OFFSET) ||
                   (aw_addr == status_flag_pkg::IRQ_CLEAR_OFFSET) ||
                   (aw_addr == status_flag_pkg::IRQ_STATUS_OFFSET);

  assign bus_status_wr = write_go && w_lane0 &&
                         (aw_addr == status_flag_pkg::STATUS_OFFSET);
  assign bus_wbyte = w_byte;
  assign irq_clear = (write_go && w_lane0 &&
                      aw_addr == status_flag_pkg::IRQ_CLEAR_OFFSET) ?
                     w_byte[status_flag_pkg::EV_COUNT-1:0] : '0;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= status_flag_pkg::RESP_OKAY;
      irq_enable <= status_flag_pkg::EV_RESET;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[3:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_byte <= S_AXI_WDATA[7:0];
        w_lane0 <= S_AXI_WSTRB[0];
      end
      if (write_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_mapped ? status_flag_pkg::RESP_OKAY :
                                   status_flag_pkg::RESP_SLVERR;
        if (w_lane0 && aw_addr == status_flag_pkg::IRQ_ENABLE_OFFSET) begin
          irq_enable <= w_byte[status_flag_pkg::EV_COUNT-1:0];
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------
  wire [3:0] rd_addr = {S_AXI_ARADDR[3:2], 2'b00};
  wire rd_mapped = (rd_addr == status_flag_pkg::STATUS_OFFSET) ||
                   (rd_addr == status_flag_pkg::IRQ_STATUS_OFFSET) ||
                   (rd_addr == status_flag_pkg::IRQ_ENABLE_OFFSET) ||
                   (rd_addr == status_flag_pkg::IRQ_CLEAR_OFFSET);
  wire [7:0] rd_byte =
    (rd_addr == status_flag_pkg::STATUS_OFFSET) ? O_STATUS :
    (rd_addr == status_flag_pkg::IRQ_STATUS_OFFSET) ? {5'h00, irq_status} :
    (rd_addr == status_flag_pkg::IRQ_ENABLE_OFFSET) ? {5'h00, irq_enable} :
    8'h00;  // clear register reads zero

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= status_flag_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h000000, rd_byte};
      S_AXI_RRESP <= rd_mapped ? status_flag_pkg::RESP_OKAY :
                                 status_flag_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: tb/core_side_model.sv
// core_side_model: stands in for the alu, watchdog and reset logic.
// assumes one strobe bundle at a time; every strobe is one cycle long.
`timescale 1ns/1ns
`default_nettype none
module core_side_model (
  input wire logic i_clk, // core clock
  output var status_flag_pkg::alu_report_t o_alu, // alu report
  output var status_flag_pkg::core_events_t o_evt, // event strobes
  output var status_flag_pkg::core_write_t o_cwr // direct writes
);
  // ----------------------------------------
  // strobes
  // ----------------------------------------
  initial begin
    o_alu = '0;
    o_evt = '0;
    o_cwr = '0;
  end
  // payload is inverted once released, so a design must not read it then
  task pulse(input status_flag_pkg::alu_report_t a, input status_flag_pkg::core_events_t e,
             input status_flag_pkg::core_write_t w);
    @(posedge i_clk);
    o_alu <= a;
    o_evt <= e;
    o_cwr <= w;
    @(posedge i_clk);
    o_alu <= status_flag_pkg::alu_report_t'({1'b0, ~a[11:0]});
    o_evt <= '0;
    o_cwr <= status_flag_pkg::core_write_t'({3'b000, ~w[10:0]});
  endtask
endmodule
`default_nettype wire

// file: tb/status_flag_register_bench.sv
// status_flag_register_bench: drives core strobes, pins and register bus.
// assumes the partner model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module status_flag_register_bench;
  logic I_CORE_CLK = 1'b0;
  logic I_RESETN = 1'b0;
  logic I_SUPPLY_BELOW = 1'b0;
  logic I_BROWNOUT_EN = 1'b0;
  logic I_BROWNOUT_HIGH = 1'b0;
  logic [3:0] S_AXI_AWADDR = 4'h0;
  logic [3:0] S_AXI_ARADDR = 4'h0;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 1'b0;
  logic S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0;
  logic S_AXI_RREADY = 1'b0;
  wire status_flag_pkg::alu_report_t I_ALU;
  wire status_flag_pkg::core_events_t I_EVT;
  wire status_flag_pkg::core_write_t I_CORE_WR;
  wire logic [7:0] O_STATUS;
  wire logic [31:0] S_AXI_RDATA;
  wire logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire logic O_BANK_SELECT, O_THRESHOLD_HIGH, O_IRQ, S_AXI_AWREADY, S_AXI_WREADY;
  wire logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  int n_fail = 0;
  int check_count = 0;
  int es = 0;
  int ei = 0;
  int k;
  logic [1:0] r;
  logic [31:0] d;
  status_flag_pkg::alu_report_t a;

  always #4 I_CORE_CLK = ~I_CORE_CLK;
  core_side_model core (.i_clk(I_CORE_CLK), .o_alu(I_ALU), .o_evt(I_EVT), .o_cwr(I_CORE_WR));
  status_flag_register DUT (.*);

  // ----------------------------------------
  // reporting and bus tasks
  // ----------------------------------------
  task end_sim;
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // channels are judged at the falling edge, half a cycle before the rising edge, and released just after that rising edge
  task axw(input logic [3:0] ad, input logic [31:0] dt, output logic [1:0] rp);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge I_CORE_CLK);
    S_AXI_AWADDR <= ad;
    S_AXI_WDATA <= dt;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge I_CORE_CLK);
      ta = S_AXI_AWVALID & S_AXI_AWREADY;
      tw = S_AXI_WVALID & S_AXI_WREADY;
      tb = S_AXI_BVALID;
      rp = S_AXI_BRESP;
      @(posedge I_CORE_CLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      if (tb) S_AXI_BREADY <= 1'b0;
    end
    if (!tb) begin
      n_fail++;
      end_sim();
    end
  endtask
  task axr(input logic [3:0] ad, output logic [31:0] dt, output logic [1:0] rp);
    logic ta, tb;
    tb = 1'b0;
    @(posedge I_CORE_CLK);
    S_AXI_ARADDR <= ad;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge I_CORE_CLK);
      ta = S_AXI_ARVALID & S_AXI_ARREADY;
      tb = S_AXI_RVALID;
      {dt, rp} = {S_AXI_RDATA, S_AXI_RRESP};
      @(posedge I_CORE_CLK);
      if (ta) S_AXI_ARVALID <= 1'b0;
      if (tb) S_AXI_RREADY <= 1'b0;
    end
    if (!tb) begin
      n_fail++;
      end_sim();
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h4538));
    repeat (16) @(posedge I_CORE_CLK);
    I_RESETN <= 1'b1;
    axr(status_flag_pkg::STATUS_OFFSET, d, r);
    chk("reset status", 32'h0, d);
    axw(status_flag_pkg::IRQ_ENABLE_OFFSET, 32'h7, r);
    // every mix of strobes, so priorities between them are exercised
    for (k = 0; k < 16; k++) begin
      core.pulse('0, status_flag_pkg::core_events_t'(k[3:0]), '0);
      if (k[3] | k[2] | k[0]) es &= 'hef;
      if (k[1]) es |= 'h10;
      if (k[3] | k[0]) es &= 'hf7;
      if (k[2]) es |= 'h08;
      ei |= (k[1] ? 1 : 0) | (k[2] ? 4 : 0);
      #1;
      chk("status", es, O_STATUS);
      chk("irq", ei != 0, O_IRQ);
    end
    axr(status_flag_pkg::IRQ_STATUS_OFFSET, d, r);
    chk("irq status", ei, d);
    axw(status_flag_pkg::IRQ_CLEAR_OFFSET, 32'h7, r);
    axw(status_flag_pkg::IRQ_ENABLE_OFFSET, 32'h0, r);
    core.pulse('0, 4'b0010, '0);
    es |= 'h10;
    ei = 1;
    #1;
    chk("masked irq", 1'b0, O_IRQ);
    for (k = 0; k < 12; k++) begin
      a = status_flag_pkg::alu_report_t'({1'b1, 12'($urandom)});
      if (k % 3 == 0) a.result = 8'h00;
      core.pulse(a, '0, '0);
      es = (a.result == 8'h00) ? (es | 4) : (es & 'hfb);
      if (!a.is_logic) es = (es & 'hfc) | {a.nibble_out, a.carry_out};
      #1;
      chk("alu status", es, O_STATUS);
    end
    for (k = 0; k < 8; k++) begin
      d = $urandom;
      core.pulse('0, '0, status_flag_pkg::core_write_t'({3'b100, 3'h0, d[7:0]}));
      es = (es & 'h98) | (d & 'h67);
      core.pulse('0, '0, status_flag_pkg::core_write_t'({3'b010, k[2:0], 8'h00}));
      es |= (1 << k) & 'h67;
      #1;
      chk("bit set", es, O_STATUS);
      chk("bank", (es >> 5) & 1, O_BANK_SELECT);
      core.pulse('0, '0, status_flag_pkg::core_write_t'({3'b001, k[2:0], 8'h00}));
      es &= ~((1 << k) & 'h67);
      #1;
      chk("bit clear", es, O_STATUS);
    end
    for (k = 0; k < 4; k++) begin
      d = (k == 3) ? 32'h0 : $urandom;
      axw(status_flag_pkg::STATUS_OFFSET, d, r);
      es = (es & 'h98) | (d & 'h67);
      axr(status_flag_pkg::STATUS_OFFSET, d, r);
      chk("bus status", es, d);
    end
    // the slave drops the two low address bits, so offset 2 lands on the status word
    axw(4'h2, 32'hff, r);
    es = (es & 'h98) | 'h67;
    chk("aliased wresp", status_flag_pkg::RESP_OKAY, r);
    axr(4'h2, d, r);
    chk("aliased rresp", status_flag_pkg::RESP_OKAY, r);
    chk("aliased rdata", es, d);
    {I_SUPPLY_BELOW, I_BROWNOUT_EN, I_BROWNOUT_HIGH} <= 3'b111;
    repeat (6) @(posedge I_CORE_CLK);
    #1;
    chk("supply low", es | 'h80, O_STATUS);
    chk("threshold", 1'b1, O_THRESHOLD_HIGH);
    I_BROWNOUT_EN <= 1'b0;
    axr(status_flag_pkg::IRQ_STATUS_OFFSET, d, r);
    chk("irq status", ei | 2, d);
    repeat (6) @(posedge I_CORE_CLK);
    #1;
    chk("brownout off", es, O_STATUS);
    end_sim();
  end
endmodule
`default_nettype wire

// file: tb/status_flag_register_sva.sv
// status_flag_register_sva: port-level checks of the status register.
// assumes core strobes and pins change just after I_CORE_CLK edges.
`timescale 1ns/1ns
`default_nettype none
module status_flag_register_sva (
  input wire logic I_CORE_CLK, // core clock
  input wire logic I_RESETN, // sync reset, active low
  input wire status_flag_pkg::alu_report_t I_ALU, // alu report
  input wire status_flag_pkg::core_events_t I_EVT, // event strobes
  input wire status_flag_pkg::core_write_t I_CORE_WR, // core write
  input wire logic I_SUPPLY_BELOW, // comparator
  input wire logic I_BROWNOUT_EN, // brown-out enable
  input wire logic [7:0] O_STATUS, // status byte
  input wire logic O_BANK_SELECT, // bank select
  input wire logic S_AXI_RVALID, // read valid
  input wire logic S_AXI_RREADY, // read ready
  input wire logic [31:0] S_AXI_RDATA // read data
);
  // ----------------------------------------
  // flag relations
  // ----------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  // the pins pass two synchronisers and a flop, so four samples settle it
  wire logic low_in = I_SUPPLY_BELOW & I_BROWNOUT_EN;
  wire logic sw_clr = I_EVT.wdt_clear | I_EVT.brownout;

  a_expired_set: assert property (I_EVT.wdt_timeout |=> O_STATUS[4])
    else $error("expired flag not set");
  a_expired_clear: assert property ((sw_clr | I_EVT.sleep) && !I_EVT.wdt_timeout
    |=> !O_STATUS[4]) else $error("expired flag not cleared");
  a_sleep_set: assert property (I_EVT.sleep |=> O_STATUS[3])
    else $error("sleep flag not set");
  a_sleep_clear: assert property (sw_clr && !I_EVT.sleep |=> !O_STATUS[3])
    else $error("sleep flag not cleared");
  a_null_result: assert property (I_ALU.valid |=> O_STATUS[2] == ($past(I_ALU.result) == 8'h00))
    else $error("null flag wrong");
  a_arith_flags: assert property (I_ALU.valid && !I_ALU.is_logic
    |=> O_STATUS[1] == $past(I_ALU.nibble_out) && O_STATUS[0] == $past(I_ALU.carry_out))
    else $error("carry flags wrong");
  a_bank_follows: assert property (O_BANK_SELECT == O_STATUS[5])
    else $error("bank output differs");
  a_hw_bits_hold: assert property (I_CORE_WR.write && I_EVT == '0 |=> $stable(O_STATUS[4:3]))
    else $error("hardware bits written");
  a_supply_set: assert property (low_in [*4] |-> O_STATUS[7])
    else $error("supply low not shown");
  a_supply_clear: assert property (!low_in [*4] |-> !O_STATUS[7])
    else $error("supply low stuck");
  a_read_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  c_arith: cover property (I_ALU.valid && !I_ALU.is_logic);
  c_sleep: cover property (I_EVT.sleep && I_EVT.wdt_clear);
  c_supply: cover property ($rose(O_STATUS[7]));
endmodule
bind status_flag_register status_flag_register_sva chk (.*);
`default_nettype wire
